// *** design/usb_ctl_pkg.sv ***
// Constants, register map and carrier types for the USB device control slice.
// Assumes one 50 MHz clock and a plain byte-wide register port from the processor.
//
// Summary of operation
// - Enable register per pending register, none for resume.
// - Enable 0 blocks, 1 passes interrupt.
// - Endpoint enables bits 0-4, all set at reset.
// - Bus-reset enable bit 2 set, suspend bit 0 clear.
// - Capture frame number bytes on each SOF.
// - Frame bytes read-only, core-written, reset zero.
// - Endpoint select steers indexed register access.
// - Endpoint 0 status shares first IN status address.
// - Writing early-end service clears early-end flag.
// - Writing receive service clears received-packet flag.
// - Stall request stalls control transfer; 0 ends it.
// - Early end before data-phase-end sets flag, interrupts, flushes, blocks FIFO.
// - Processor sets data-phase-end; device clears it.
// - Protocol violation sets stall-sent; processor writes 0.
// - Transmit-loaded set by processor, cleared after sending.
// - Valid packet sets received-packet flag and interrupts.
// - Pending bits clear only on writing one.
// - Endpoint 0 pending set by five flag events.
// - Bus-reset pending bit 2, suspend pending bit 0.
package usb_ctl_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [31:0] ADDR_EP_PENDING  = 32'h44a00148;
    localparam logic [31:0] ADDR_BUS_PENDING = 32'h44a00158;
    localparam logic [31:0] ADDR_EP_ENABLE   = 32'h44a0015c;
    localparam logic [31:0] ADDR_BUS_ENABLE  = 32'h44a0016c;
    localparam logic [31:0] ADDR_FRAME_LOW   = 32'h44a00170;
    localparam logic [31:0] ADDR_FRAME_HIGH  = 32'h44a00174;
    localparam logic [31:0] ADDR_EP_SELECT   = 32'h44a00178;
    localparam logic [31:0] ADDR_CTRL_STATUS = 32'h44a00184;

    // ==========================================================
    // Reset values and masks
    localparam logic [7:0] EP_ENABLE_RESET  = 8'hff;
    localparam logic [7:0] EP_ENABLE_MASK   = 8'h1f;
    localparam logic [7:0] BUS_ENABLE_RESET = 8'h04;
    localparam logic [7:0] BUS_ENABLE_MASK  = 8'h05;
    localparam logic [7:0] BUS_PENDING_MASK = 8'h07;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;
    localparam logic [7:0] CONTROL_ENDPOINT = 8'h00;

    // ==========================================================
    // Bit positions
    localparam int BIT_SUSPEND     = 0;
    localparam int BIT_RESUME      = 1;
    localparam int BIT_BUS_RESET   = 2;
    localparam int BIT_EP0         = 0;
    localparam int CS_RX_FLAG      = 0;
    localparam int CS_TX_LOADED    = 1;
    localparam int CS_STALL_SENT   = 2;
    localparam int CS_DATA_END     = 3;
    localparam int CS_EARLY_END    = 4;
    localparam int CS_STALL_REQ    = 5;
    localparam int CS_RX_SERVICE   = 6;
    localparam int CS_EARLY_SVC    = 7;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    // One-cycle event pulses from the USB protocol engine.
    typedef struct packed {
        logic        sof;
        logic [10:0] frame;
        logic        rx_packet;
        logic        tx_sent;
        logic        stall_sent;
        logic        early_end;
        logic        status_done;
        logic        bus_reset;
        logic        resume;
        logic        suspend;
        logic [3:0]  ep_event;
    } usb_evt_type;

    typedef struct packed {
        logic stall;
        logic flush;
        logic fifo_block;
        logic tx_loaded;
        logic data_end;
    } ep0_ctl_type;

endpackage

// *** design/usb_int_ep0_ctl.sv ***
// Interrupt enables, pending bits, frame capture, endpoint select and endpoint 0 status.
// Assumes the protocol engine gives one-cycle event pulses synchronous to i_ref_clk.
module usb_int_ep0_ctl
    import usb_ctl_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire reg_req_type i_req,
    output logic [7:0]       o_rdata,
    input  wire usb_evt_type i_evt,
    output ep0_ctl_type      o_ep0,
    output logic [7:0]       o_ep_select,
    output logic             o_irq
);

    // ==========================================================
    // Decode
    logic [7:0] ep_enable, bus_enable, ep_pending, bus_pending;
    logic [7:0] frame_low, frame_high, ep_select;
    logic       rx_flag, tx_loaded, stall_sent, data_end, early_end, stall_req, flush;

    wire sel_ep_pend  = i_req.addr == ADDR_EP_PENDING;
    wire sel_bus_pend = i_req.addr == ADDR_BUS_PENDING;
    wire sel_ep_en    = i_req.addr == ADDR_EP_ENABLE;
    wire sel_bus_en   = i_req.addr == ADDR_BUS_ENABLE;
    wire sel_flo      = i_req.addr == ADDR_FRAME_LOW;
    wire sel_fhi      = i_req.addr == ADDR_FRAME_HIGH;
    wire sel_idx      = i_req.addr == ADDR_EP_SELECT;
    wire sel_cs       = (i_req.addr == ADDR_CTRL_STATUS) && (ep_select == CONTROL_ENDPOINT);
    wire wr_cs        = i_req.wr && sel_cs;
    wire [7:0] wd     = i_req.wdata;

    // Endpoint 0 flag events: set by the processor or the engine, cleared by the other side or by service bits.
    wire rx_clr   = wr_cs && wd[CS_RX_SERVICE];
    wire early_clr = wr_cs && wd[CS_EARLY_SVC];
    // Stall request blocks a new transmit-loaded set.
    wire tx_set   = wr_cs && wd[CS_TX_LOADED] && !stall_req;
    wire tx_clr   = i_evt.tx_sent && tx_loaded;
    wire de_set   = wr_cs && wd[CS_DATA_END];
    wire de_clr   = (i_evt.status_done || i_evt.early_end) && data_end;
    wire early_set = i_evt.early_end && !data_end;
    wire ss_clr   = wr_cs && !wd[CS_STALL_SENT];

    wire ep0_evt  = (i_evt.rx_packet && !rx_flag) || tx_clr || i_evt.stall_sent
                  || early_set || de_clr;

    // Pending: events set, write of one clears; set wins over clear.
    wire [7:0] ep_evt_vec  = {3'b000, i_evt.ep_event, ep0_evt};
    wire [7:0] bus_evt_vec = {5'b00000, i_evt.bus_reset, i_evt.resume, i_evt.suspend};
    wire [7:0] ep_wclr     = (i_req.wr && sel_ep_pend) ? wd : BYTE_ZERO;
    wire [7:0] bus_wclr    = (i_req.wr && sel_bus_pend) ? wd : BYTE_ZERO;
    wire [7:0] next_ep_pending  = (ep_pending & ~ep_wclr) | (ep_evt_vec & EP_ENABLE_MASK);
    wire [7:0] next_bus_pending = (bus_pending & ~bus_wclr) | (bus_evt_vec & BUS_PENDING_MASK);

    // Resume has no enable bit so it always passes.
    wire [7:0] bus_gate = bus_enable | (8'h01 << BIT_RESUME);
    wire next_irq = |(ep_pending & ep_enable) | |(bus_pending & bus_gate);

    wire [7:0] cs_view = {2'b00, stall_req, early_end, data_end, stall_sent, tx_loaded, rx_flag};
    wire [7:0] next_rdata =
        sel_ep_pend  ? ep_pending :
        sel_bus_pend ? bus_pending :
        sel_ep_en    ? ep_enable :
        sel_bus_en   ? bus_enable :
        sel_flo      ? frame_low :
        sel_fhi      ? frame_high :
        sel_idx      ? ep_select :
        sel_cs       ? cs_view : BYTE_ZERO;

    // ==========================================================
    // Registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ep_enable  <= EP_ENABLE_RESET & EP_ENABLE_MASK;
            bus_enable <= BUS_ENABLE_RESET;
            ep_select  <= BYTE_ZERO;
        end else if (i_req.wr) begin
            if (sel_ep_en) ep_enable <= wd & EP_ENABLE_MASK;
            if (sel_bus_en) bus_enable <= wd & BUS_ENABLE_MASK;
            if (sel_idx) ep_select <= wd;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frame_low  <= BYTE_ZERO;
            frame_high <= BYTE_ZERO;
        end else if (i_evt.sof) begin
            frame_low  <= i_evt.frame[7:0];
            frame_high <= {5'b00000, i_evt.frame[10:8]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ep_pending  <= BYTE_ZERO;
            bus_pending <= BYTE_ZERO;
            o_irq       <= 1'b0;
            o_rdata     <= BYTE_ZERO;
        end else begin
            ep_pending  <= next_ep_pending;
            bus_pending <= next_bus_pending;
            o_irq       <= next_irq;
            o_rdata     <= i_req.rd ? next_rdata : BYTE_ZERO;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_flag    <= 1'b0;
            tx_loaded  <= 1'b0;
            stall_sent <= 1'b0;
            data_end   <= 1'b0;
            early_end  <= 1'b0;
            stall_req  <= 1'b0;
            flush      <= 1'b0;
        end else begin
            rx_flag    <= i_evt.rx_packet | (rx_flag & ~rx_clr);
            tx_loaded  <= tx_set | (tx_loaded & ~tx_clr & ~early_set);
            stall_sent <= i_evt.stall_sent | (stall_sent & ~ss_clr);
            data_end   <= de_set | (data_end & ~de_clr);
            early_end  <= early_set | (early_end & ~early_clr);
            if (wr_cs) stall_req <= wd[CS_STALL_REQ];
            flush      <= early_set;
        end
    end

    // ==========================================================
    // Outputs to the protocol engine
    assign o_ep0.stall      = stall_req;
    assign o_ep0.flush      = flush;
    assign o_ep0.fifo_block = early_end;
    assign o_ep0.tx_loaded  = tx_loaded;
    assign o_ep0.data_end   = data_end;
    assign o_ep_select      = ep_select;

endmodule

// *** test/usb_int_ep0_ctl_assertions.sv ***
// Port-level checks for the endpoint 0 control slice.
// Assumes one clock domain and the asynchronous active-low reset.
module usb_int_ep0_ctl_assertions
    import usb_ctl_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire reg_req_type i_req,
    input wire logic [7:0]  o_rdata,
    input wire usb_evt_type i_evt,
    input wire ep0_ctl_type o_ep0,
    input wire logic [7:0]  o_ep_select,
    input wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire logic cs_wr = i_req.wr && i_req.addr == ADDR_CTRL_STATUS && o_ep_select == CONTROL_ENDPOINT;
    wire logic rd_at = i_req.rd && !i_req.wr;
    a_select_write: assert property (i_req.wr && i_req.addr == ADDR_EP_SELECT |=>
        o_ep_select == $past(i_req.wdata)) else $error("select not written");
    a_frame_high_pad: assert property (rd_at && i_req.addr == ADDR_FRAME_HIGH |=>
        o_rdata[7:3] == 5'h00) else $error("frame high padding");
    a_enable_width: assert property (rd_at && i_req.addr == ADDR_EP_ENABLE |=>
        o_rdata[7:5] == 3'h0) else $error("endpoint enable width");
    a_bus_reserved: assert property (rd_at && i_req.addr == ADDR_BUS_ENABLE |=>
        !o_rdata[1]) else $error("reserved enable bit");
    a_tx_load_set: assert property (cs_wr && i_req.wdata[1] && !i_req.wdata[5] && !o_ep0.stall
        && !i_evt.tx_sent |=> o_ep0.tx_loaded) else $error("tx loaded not set");
    // A processor set in the same cycle wins over the engine's clear.
    a_tx_load_clear: assert property (o_ep0.tx_loaded && i_evt.tx_sent && !(cs_wr && i_req.wdata[1])
        |=> !o_ep0.tx_loaded)
        else $error("tx loaded not cleared");
    a_stall_follow: assert property (cs_wr |=> o_ep0.stall == $past(i_req.wdata[5]))
        else $error("stall request mismatch");
    a_data_end_clear: assert property (i_evt.status_done && !(cs_wr && i_req.wdata[3]) |=> !o_ep0.data_end)
        else $error("data end kept");
    a_early_flush: assert property (i_evt.early_end && !o_ep0.data_end |=> o_ep0.flush && o_ep0.fifo_block)
        else $error("early end without flush");
endmodule

bind usb_int_ep0_ctl usb_int_ep0_ctl_assertions chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(i_req),
    .o_rdata(o_rdata), .i_evt(i_evt), .o_ep0(o_ep0), .o_ep_select(o_ep_select), .o_irq(o_irq));

// *** test/usb_host_model.sv ***
// Host-side event source: turns a bench command into one-cycle bus event pulses.
// Assumes commands arrive synchronous to i_ref_clk, one at a time.
module usb_host_model
    import usb_ctl_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [10:0] i_frame,
    output usb_evt_type      o_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [15:0] hit = 16'h0001 << i_cmd;
    // Outside a start-of-frame the frame field carries garbage so a stale capture shows up.
    always_ff @(posedge i_ref_clk) begin
        o_evt <= {hit[1], hit[1] ? i_frame : ~i_frame, hit[2], hit[3], hit[4], hit[5], hit[6],
                  hit[7], hit[8], hit[9], 4'h0};
    end
endmodule

// *** test/usb_device_int_enable_ep0_control_test.sv ***
// Self-checking bench for the endpoint 0 control slice.
// Assumes the register port answers reads one cycle after the strobe.
module usb_device_int_enable_ep0_control_test
    import usb_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    reg_req_type req = '0;
    logic [3:0]  cmd = 4'h0;
    logic [10:0] frame = 11'h000;
    logic [7:0]  rdata, sel;
    usb_evt_type evt;
    ep0_ctl_type ep0;
    logic        irq;
    int          mismatches = 0;
    int          n_tests = 0;
    usb_host_model host (.i_ref_clk(clk), .i_cmd(cmd), .i_frame(frame), .o_evt(evt));
    usb_int_ep0_ctl dut (.i_ref_clk(clk), .i_rstn(rstn), .i_req(req), .o_rdata(rdata), .i_evt(evt),
        .o_ep0(ep0), .o_ep_select(sel), .o_irq(irq));
    initial begin
        forever #10 clk = ~clk;
    end
    // ==========================================
    // Bus and compare tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk); req.addr <= a; req.wdata <= d; req.wr <= 1'b1;
        @(posedge clk); req.wr <= 1'b0; #1;
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e);
        @(posedge clk); req.addr <= a; req.rd <= 1'b1;
        @(posedge clk); req.rd <= 1'b0; #1; chk(rdata, e);
    endtask
    // The flag lands two edges after the command and the interrupt one edge later.
    task ev(input logic [3:0] c, input logic [10:0] f);
        @(posedge clk); cmd <= c; frame <= f;
        @(posedge clk); cmd <= 4'h0; repeat (2) @(posedge clk); #1;
    endtask
    // ==========================================
    // Scenarios
    task reset_values;
        rd(ADDR_EP_ENABLE, 8'h1f);
        rd(ADDR_BUS_ENABLE, 8'h04);
        rd(ADDR_FRAME_LOW, 8'h00);
        rd(ADDR_EP_SELECT, 8'h00);
        rd(ADDR_CTRL_STATUS, 8'h00);
    endtask
    task enables_rw;
        wr(ADDR_EP_ENABLE, 8'h00); rd(ADDR_EP_ENABLE, 8'h00);
        wr(ADDR_BUS_ENABLE, 8'hff); rd(ADDR_BUS_ENABLE, 8'h05);
        wr(ADDR_FRAME_LOW, 8'h55); rd(ADDR_FRAME_LOW, 8'h00);
        rd(32'h44a00100, 8'h00);
        ev(4'h1, 11'h5a3); rd(ADDR_FRAME_LOW, 8'ha3); rd(ADDR_FRAME_HIGH, 8'h05);
    endtask
    task masked_events;
        ev(4'h2, 11'h0); chk({7'h0, irq}, 8'h00); rd(ADDR_CTRL_STATUS, 8'h01);
        wr(ADDR_EP_ENABLE, 8'h01); @(posedge clk); #1; chk({7'h0, irq}, 8'h01);
        wr(ADDR_EP_PENDING, 8'h00); rd(ADDR_EP_PENDING, 8'h01);
        wr(ADDR_EP_PENDING, 8'h01); rd(ADDR_EP_PENDING, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'h60); rd(ADDR_CTRL_STATUS, 8'h20);
        wr(ADDR_CTRL_STATUS, 8'h00); rd(ADDR_CTRL_STATUS, 8'h00);
        ev(4'h9, 11'h0); chk({7'h0, irq}, 8'h01); rd(ADDR_BUS_PENDING, 8'h01);
        wr(ADDR_BUS_PENDING, 8'h01); wr(ADDR_BUS_ENABLE, 8'h00);
        ev(4'h8, 11'h0); chk({7'h0, irq}, 8'h01); wr(ADDR_BUS_PENDING, 8'h02);
        ev(4'h7, 11'h0); chk({7'h0, irq}, 8'h00); rd(ADDR_BUS_PENDING, 8'h04);
        wr(ADDR_BUS_PENDING, 8'h04);
    endtask
    task tx_transfer;
        wr(ADDR_CTRL_STATUS, 8'h0a); rd(ADDR_CTRL_STATUS, 8'h0a);
        ev(4'h3, 11'h0); rd(ADDR_CTRL_STATUS, 8'h08); chk({7'h0, irq}, 8'h01);
        wr(ADDR_EP_PENDING, 8'h01); ev(4'h6, 11'h0); rd(ADDR_CTRL_STATUS, 8'h00);
        rd(ADDR_EP_PENDING, 8'h01); wr(ADDR_EP_PENDING, 8'h01);
    endtask
    task faults;
        ev(4'h4, 11'h0); rd(ADDR_CTRL_STATUS, 8'h04);
        wr(ADDR_EP_SELECT, 8'h01); rd(ADDR_CTRL_STATUS, 8'h00);
        wr(ADDR_EP_SELECT, 8'h00); wr(ADDR_CTRL_STATUS, 8'h00); rd(ADDR_CTRL_STATUS, 8'h00);
        ev(4'h5, 11'h0); rd(ADDR_CTRL_STATUS, 8'h10); chk({7'h0, ep0.fifo_block}, 8'h01);
        wr(ADDR_CTRL_STATUS, 8'h80); rd(ADDR_CTRL_STATUS, 8'h00);
    endtask
    task test_done;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        reset_values();
        enables_rw();
        masked_events();
        tx_transfer();
        faults();
        test_done();
    end
endmodule
